/* nbp_pkg.sv */
// Purpose: Shared constants, types and helpers of the block protection logic
// Assumes: 100 MHz ref_clk, serial link clocked by the host
// Notes:   Field positions are bit indices of the feature bytes
package nbp_pkg;
	// Opcodes
	localparam logic [7:0] OP_WREN   = 8'h06;
	localparam logic [7:0] OP_WRDI   = 8'h04;
	localparam logic [7:0] OP_SETF   = 8'h1f;
	localparam logic [7:0] OP_GETF   = 8'h0f;
	localparam logic [7:0] OP_PEXEC  = 8'h10;
	localparam logic [7:0] OP_ERASE  = 8'hd8;
	localparam logic [7:0] OP_PROT   = 8'h2c;
	localparam logic [7:0] OP_RESET  = 8'hff;
	localparam logic [7:0] OP_PREAD  = 8'h13;
	localparam logic [7:0] OP_RCACHE = 8'h03;
	// Feature addresses
	localparam logic [7:0] FA_LOCK   = 8'ha0;
	localparam logic [7:0] FA_CFG    = 8'hb0;
	localparam logic [7:0] FA_STAT   = 8'hc0;
	// Block lock byte
	localparam int         LK_RWD    = 7;
	localparam int         LK_BP_HI  = 6;
	localparam int         LK_BP_LO  = 3;
	localparam int         LK_TB     = 2;
	localparam int         LK_HPB    = 1;
	localparam int         LK_FRZ_LO = 2;
	localparam logic [7:0] LOCK_RESET = 8'h7c;
	localparam logic [7:0] LOCK_WMASK = 8'hfe;
	// Configuration byte
	localparam int         CF_M2     = 7;
	localparam int         CF_M1     = 6;
	localparam int         CF_LOT    = 5;
	localparam int         CF_M0     = 1;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_PSTAT  = 3'h1;
	localparam logic [2:0] MODE_PDIS   = 3'h7;
	// Status byte
	localparam int         ST_OIP    = 0;
	localparam int         ST_WEL    = 1;
	localparam int         ST_EFAIL  = 2;
	localparam int         ST_PFAIL  = 3;
	localparam logic [7:0] ST_PROT_FAIL = 8'h08;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONES = 8'hff;
	// Addressing
	localparam int         BLK_W      = 10;
	localparam int         ROW_BLK_LO = 6;
	localparam int         ROW_W      = 17;
	localparam int         GRP_LO     = 8;
	localparam int         GRP_W      = 4;
	localparam int         GIDX_HI    = 5;
	localparam int         GIDX_LO    = 2;
	localparam int         NUM_GROUPS = 12;
	localparam logic [GRP_W-1:0] GRP_LAST   = 4'hb;
	localparam logic [BLK_W-1:0] PERM_BLKS  = 10'h030;
	localparam logic [BLK_W:0]   BLK_COUNT  = 11'h400;
	localparam logic [3:0]       BP_NONE    = 4'h0;
	localparam logic [3:0]       BP_MAXSTEP = 4'ha;
	// Frame bytes
	localparam logic [2:0] NB_MAX    = 3'h7;
	localparam logic [2:0] NB_ONE    = 3'h1;
	localparam logic [2:0] NB_SETF   = 3'h3;
	localparam logic [2:0] NB_ADDR   = 3'h4;
	localparam logic [2:0] BIT_LAST  = 3'h7;
	localparam logic [2:0] IDX_GETF_ADDR   = 3'h1;
	localparam logic [2:0] IDX_CACHE_DUMMY = 3'h3;
	// Timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int PROGRAM_TIME_NS = 200000;
	localparam int ERASE_TIME_NS   = 2000000;
	localparam int READ_TIME_NS    = 25000;
	localparam int READ_CYCLES     = READ_TIME_NS / CLK_PERIOD_NS;
	localparam int TMR_W           = 18;

	typedef enum logic {NBP_IDLE, NBP_BUSY} nbp_state_t;
	typedef enum logic [2:0] {NBP_K_PROG, NBP_K_ERASE, NBP_K_PROT, NBP_K_DIS, NBP_K_READ} nbp_kind_t;

	function automatic logic nbp_range_locked(input logic tb, input logic [3:0] bp, input logic [BLK_W-1:0] blk);
		logic [BLK_W:0] span;
		span = (BLK_W+1)'(1) << (bp - 4'h1);
		if (bp == BP_NONE)
			nbp_range_locked = 1'b0;
		else if (bp > BP_MAXSTEP)
			nbp_range_locked = 1'b1;
		else if (tb)
			nbp_range_locked = ({1'b0, blk} < span);
		else
			nbp_range_locked = ({1'b0, blk} >= (BLK_COUNT - span));
	endfunction : nbp_range_locked

	function automatic logic nbp_perm_hit(input logic [NUM_GROUPS-1:0] grp, input logic [BLK_W-1:0] blk);
		nbp_perm_hit = (blk < PERM_BLKS) && grp[blk[GIDX_HI:GIDX_LO]];
	endfunction : nbp_perm_hit

	function automatic logic [2:0] nbp_to_gray(input logic [2:0] b);
		nbp_to_gray = b ^ (b >> 1);
	endfunction : nbp_to_gray

	function automatic logic [2:0] nbp_from_gray(input logic [2:0] g);
		nbp_from_gray = {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
	endfunction : nbp_from_gray
endpackage : nbp_pkg

/* nbp_spi_link.sv */
// Purpose: Serial link end on the host clock, bytes in, feature bytes out
// Assumes: Mode 0 framing, whole bytes per frame
// Notes:   Mirror inputs are frozen by the core while a frame is open
module nbp_spi_link
(
	input  wire logic       sck,
	input  wire logic       cs_n,
	input  wire logic       rstn,
	input  wire logic       si,
	output logic            so,
	output logic            so_oe,
	output logic [7:0]      byte_data,
	output logic [2:0]      byte_gray,
	input  wire logic [7:0] mir_lock,
	input  wire logic [7:0] mir_cfg,
	input  wire logic [7:0] mir_stat,
	input  wire logic [7:0] mir_cache
);
	import nbp_pkg::*;

	typedef struct packed {
		logic [2:0] bitc;
		logic [2:0] idx;
		logic [6:0] sh;
		logic [7:0] op;
		logic [7:0] out;
		logic       drv;
	} nbp_frame_t;

	// Survives frame end so the core never sees a false byte count
	typedef struct packed {
		logic [2:0] bin;
		logic [2:0] gray;
		logic [7:0] data;
	} nbp_xfer_t;

	nbp_frame_t f_q, f_d;
	nbp_xfer_t  x_q, x_d;
	logic [7:0] nb;

	always_comb begin
		f_d = f_q;
		x_d = x_q;
		nb = {f_q.sh, si};
		f_d.sh = nb[6:0];
		f_d.bitc = f_q.bitc + 3'h1;
		f_d.out = {f_q.out[6:0], 1'b0};
		if (f_q.bitc == BIT_LAST) begin
			x_d.data = nb;
			x_d.bin = x_q.bin + 3'h1;
			x_d.gray = nbp_to_gray(x_d.bin);
			if (f_q.idx != NB_MAX)
				f_d.idx = f_q.idx + 3'h1;
			if (f_q.idx == 3'h0)
				f_d.op = nb;
			if (f_q.idx == IDX_GETF_ADDR && f_q.op == OP_GETF) begin
				f_d.drv = 1'b1;
				case (nb)
					FA_LOCK: f_d.out = mir_lock;
					FA_CFG:  f_d.out = mir_cfg;
					FA_STAT: f_d.out = mir_stat;
					default: f_d.out = BYTE_ZERO;
				endcase
			end
			if (f_q.idx >= IDX_CACHE_DUMMY && f_q.op == OP_RCACHE) begin
				f_d.drv = 1'b1;
				f_d.out = mir_cache;
			end
		end
	end

	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n)
			f_q <= '0;
		else
			f_q <= f_d;
	end

	always_ff @(posedge sck or negedge rstn) begin
		if (!rstn)
			x_q <= '0;
		else
			x_q <= x_d;
	end

	// Data changes after the rising edge, host samples on the next one
	assign so        = f_q.out[7];
	assign so_oe     = f_q.drv & ~cs_n;
	assign byte_data = x_q.data;
	assign byte_gray = x_q.gray;
endmodule : nbp_spi_link

/* nbp_top.sv */
// Purpose: Block protection core: range lock, lock freeze, permanent groups
// Assumes: Host issues commands over the serial link, wp_n is a raw pin
// Notes:   Array itself is absent; operations only time out and report
module nbp_top
	import nbp_pkg::*;
#(
	parameter int PROG_CYCLES  = (nbp_pkg::PROGRAM_TIME_NS + nbp_pkg::CLK_PERIOD_NS - 1) / nbp_pkg::CLK_PERIOD_NS,
	parameter int ERASE_CYCLES = (nbp_pkg::ERASE_TIME_NS + nbp_pkg::CLK_PERIOD_NS - 1) / nbp_pkg::CLK_PERIOD_NS
)
(
	input  wire logic                             ref_clk,
	input  wire logic                             rstn,
	input  wire logic                             sck,
	input  wire logic                             cs_n,
	input  wire logic                             si,
	output logic                                  so,
	output logic                                  so_oe,
	input  wire logic                             wp_n,
	input  wire logic [nbp_pkg::NUM_GROUPS-1:0]   nv_groups_in,
	input  wire logic                             nv_disable_in,
	output logic [nbp_pkg::NUM_GROUPS-1:0]        nv_groups,
	output logic                                  nv_disable,
	output logic                                  busy
);
	import nbp_pkg::*;

	typedef struct packed {
		nbp_state_t            st;
		nbp_kind_t             kind;
		logic [TMR_W-1:0]      tmr;
		logic                  fail;
		logic [GRP_W-1:0]      grp;
		logic                  pbit;
		logic [7:0]            lock;
		logic [7:0]            cfg;
		logic                  lock_tight_mode;
		logic                  write_enable_latch;
		logic                  pfail;
		logic                  efail;
		logic [NUM_GROUPS-1:0] nvg;
		logic                  nvd;
		logic [7:0]            cache;
		logic [7:0]            m_lock;
		logic [7:0]            m_cfg;
		logic [7:0]            m_stat;
		logic [7:0]            m_cache;
		logic [7:0]            op;
		logic [23:0]           adr;
		logic [2:0]            nb;
		logic [2:0]            rcv;
		logic [2:0]            g1;
		logic [2:0]            g2;
		logic                  cs1;
		logic                  cs2;
		logic                  cs3;
		logic                  cs4;
		logic                  wp1;
		logic                  wp2;
	} nbp_core_t;

	nbp_core_t        q, d;
	logic [7:0]       byte_data;
	logic [2:0]       byte_gray;
	logic [7:0]       stat;
	logic [2:0]       mode;
	logic             frame_end;
	logic             hw_frz;
	logic [BLK_W-1:0] blk;
	logic [7:0]       fdat;
	logic [7:0]       faddr;

	nbp_spi_link u_link (
		.sck       (sck),
		.cs_n      (cs_n),
		.rstn      (rstn),
		.si        (si),
		.so        (so),
		.so_oe     (so_oe),
		.byte_data (byte_data),
		.byte_gray (byte_gray),
		.mir_lock  (q.m_lock),
		.mir_cfg   (q.m_cfg),
		.mir_stat  (q.m_stat),
		.mir_cache (q.m_cache)
	);

	assign stat      = {4'h0, q.pfail, q.efail, q.write_enable_latch, q.st == NBP_BUSY};
	assign mode      = {q.cfg[CF_M2], q.cfg[CF_M1], q.cfg[CF_M0]};
	// One stage behind the byte sync, so a last byte that arrives with cs_n high lands first
	assign frame_end = q.cs3 & ~q.cs4;
	assign hw_frz    = ~q.lock[LK_HPB] & q.lock[LK_RWD] & ~q.wp2;
	assign blk       = q.adr[ROW_BLK_LO+BLK_W-1:ROW_BLK_LO];
	assign faddr     = q.adr[15:8];
	assign fdat      = q.adr[7:0];

	always_comb begin
		d = q;
		d.g1 = byte_gray;
		d.g2 = q.g1;
		d.cs1 = cs_n;
		d.cs2 = q.cs1;
		d.cs3 = q.cs2;
		d.cs4 = q.cs3;
		d.wp1 = wp_n;
		d.wp2 = q.wp1;
		// Byte intake from the link
		if (nbp_from_gray(q.g2) != q.rcv) begin
			d.rcv = q.rcv + 3'h1;
			if (q.nb == 3'h0)
				d.op = byte_data;
			else
				d.adr = {q.adr[15:0], byte_data};
			if (q.nb != NB_MAX)
				d.nb = q.nb + 3'h1;
		end
		// Operation timer and completion
		if (q.st == NBP_BUSY) begin
			if (q.tmr != '0) begin
				d.tmr = q.tmr - 1'b1;
			end else begin
				d.st = NBP_IDLE;
				d.write_enable_latch = 1'b0;
				case (q.kind)
					NBP_K_PROG: d.pfail = q.fail;
					NBP_K_ERASE: d.efail = q.fail;
					NBP_K_PROT: begin
						d.pfail = q.fail;
						if (!q.fail)
							d.nvg[q.grp] = 1'b1;
					end
					NBP_K_DIS: begin
						d.pfail = q.fail;
						if (!q.fail)
							d.nvd = 1'b1;
					end
					NBP_K_READ: begin
						d.write_enable_latch = q.write_enable_latch;
						d.cache = (mode == MODE_PSTAT) ? (q.pbit ? BYTE_ZERO : BYTE_ONES) : BYTE_ONES;
					end
					default: d.st = NBP_IDLE;
				endcase
			end
		end
		// Command execution at frame end
		if (frame_end) begin
			d.nb = 3'h0;
			if (q.op == OP_RESET && q.nb == NB_ONE) begin
				d.st = NBP_IDLE;
				d.tmr = '0;
				d.cfg[CF_M2] = 1'b0;
				d.cfg[CF_M1] = 1'b0;
				d.cfg[CF_M0] = 1'b0;
				d.write_enable_latch = 1'b0;
				d.pfail = 1'b0;
				d.efail = 1'b0;
				d.lock = q.lock;
			end else if (q.st == NBP_IDLE) begin
				case (q.op)
					OP_WREN: if (q.nb == NB_ONE) d.write_enable_latch = 1'b1;
					OP_WRDI: if (q.nb == NB_ONE) d.write_enable_latch = 1'b0;
					OP_SETF: begin
						if (q.nb == NB_SETF && faddr == FA_LOCK) begin
							// Refused bits hold quietly, no fail flag raised
							if (hw_frz || q.lock_tight_mode)
								d.lock[LK_HPB] = fdat[LK_HPB];
							else
								d.lock = fdat & LOCK_WMASK;
						end
						if (q.nb == NB_SETF && faddr == FA_CFG) begin
							d.cfg = fdat;
							d.lock_tight_mode = q.lock_tight_mode | fdat[CF_LOT];
							d.cfg[CF_LOT] = d.lock_tight_mode;
						end
					end
					OP_PEXEC, OP_ERASE: begin
						if (q.nb == NB_ADDR && q.write_enable_latch) begin
							d.st = NBP_BUSY;
							d.kind = (q.op == OP_ERASE) ? NBP_K_ERASE : NBP_K_PROG;
							d.tmr = (q.op == OP_ERASE) ? TMR_W'(ERASE_CYCLES - 1) : TMR_W'(PROG_CYCLES - 1);
							d.fail = nbp_range_locked(q.lock[LK_TB], q.lock[LK_BP_HI:LK_BP_LO], blk)
								| nbp_perm_hit(q.nvg, blk);
							if (q.op == OP_PEXEC) begin
								d.pfail = 1'b0;
								if (mode == MODE_PDIS) begin
									d.kind = NBP_K_DIS;
									d.fail = (q.adr[ROW_W-1:0] != '0);
								end
							end
						end
					end
					OP_PROT: begin
						if (q.nb == NB_ADDR && q.write_enable_latch && !q.nvd) begin
							d.st = NBP_BUSY;
							d.kind = NBP_K_PROT;
							d.tmr = TMR_W'(PROG_CYCLES - 1);
							d.grp = q.adr[GRP_LO+GRP_W-1:GRP_LO];
							d.fail = (q.adr[GRP_LO+GRP_W-1:GRP_LO] > GRP_LAST);
							d.pfail = 1'b0;
							d.efail = 1'b0;
						end
					end
					OP_PREAD: begin
						if (q.nb == NB_ADDR) begin
							d.st = NBP_BUSY;
							d.kind = NBP_K_READ;
							d.tmr = TMR_W'(READ_CYCLES - 1);
							d.pbit = nbp_perm_hit(q.nvg, blk);
						end
					end
					default: d.nb = 3'h0;
				endcase
			end
		end
		// Mirrors only move while no frame is open, so the link sees them steady
		if (q.cs2) begin
			d.m_lock = q.lock;
			d.m_cfg = q.cfg;
			d.m_stat = stat;
			d.m_cache = q.cache;
		end
		if (!rstn) begin
			d = '0;
			d.st = NBP_IDLE;
			d.kind = NBP_K_PROG;
			d.lock = LOCK_RESET;
			d.cfg = CFG_RESET;
			d.cache = BYTE_ONES;
			d.nvg = nv_groups_in;
			d.nvd = nv_disable_in;
			d.cs1 = 1'b1;
			d.cs2 = 1'b1;
			d.cs3 = 1'b1;
			d.cs4 = 1'b1;
			d.wp1 = 1'b1;
			d.wp2 = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		q <= d;
	end

	assign nv_groups  = q.nvg;
	assign nv_disable = q.nvd;
	assign busy       = q.st == NBP_BUSY;

	a_power_up_lock: assert property (@(posedge ref_clk) !rstn |=> (q.lock == LOCK_RESET && !q.lock_tight_mode))
		else $error("lock byte not at power-up value");
	a_bypass_clear: assert property (@(posedge ref_clk) !rstn |=> (!q.lock[LK_RWD] && !q.lock[LK_HPB]))
		else $error("write-disable or bypass not cleared at power-up");
	a_reset_keeps: assert property (@(posedge ref_clk) disable iff (!rstn)
		(frame_end && q.op == OP_RESET && q.nb == NB_ONE) |=> (q.lock == $past(q.lock) && mode == MODE_NORMAL))
		else $error("reset command changed lock byte or kept mode");
	a_lock_refused: assert property (@(posedge ref_clk) disable iff (!rstn)
		(frame_end && q.st == NBP_IDLE && q.op == OP_SETF && q.nb == NB_SETF && faddr == FA_LOCK && (hw_frz || q.lock_tight_mode))
		|=> (q.lock[7:LK_FRZ_LO] == $past(q.lock[7:LK_FRZ_LO])
		&& q.pfail == $past(q.pfail) && q.efail == $past(q.efail)))
		else $error("frozen lock bits changed");
	a_lock_taken: assert property (@(posedge ref_clk) disable iff (!rstn)
		(frame_end && q.st == NBP_IDLE && q.op == OP_SETF && q.nb == NB_SETF && faddr == FA_LOCK
		&& q.lock[LK_HPB] && !q.lock_tight_mode) |=> q.lock[7:LK_FRZ_LO] == $past(fdat[7:LK_FRZ_LO]))
		else $error("unfrozen lock write not taken");
	a_lot_sticky: assert property (@(posedge ref_clk) disable iff (!rstn) q.lock_tight_mode |=> (q.lock_tight_mode && q.cfg[CF_LOT]))
		else $error("lock-tight dropped");
	a_locked_fails: assert property (@(posedge ref_clk) disable iff (!rstn)
		(frame_end && q.st == NBP_IDLE && q.op == OP_ERASE && q.nb == NB_ADDR && q.write_enable_latch
		&& nbp_range_locked(q.lock[LK_TB], q.lock[LK_BP_HI:LK_BP_LO], blk))
		|=> (q.st == NBP_BUSY && q.kind == NBP_K_ERASE && q.fail))
		else $error("erase of locked block not flagged");
	a_prot_no_wel: assert property (@(posedge ref_clk) disable iff (!rstn)
		(frame_end && q.st == NBP_IDLE && q.op == OP_PROT && !q.write_enable_latch) |=> (q.st == NBP_IDLE && $stable(q.nvg)))
		else $error("permanent lock ran without write enable");
	a_prot_disabled: assert property (@(posedge ref_clk) disable iff (!rstn)
		(frame_end && q.st == NBP_IDLE && q.op == OP_PROT && q.nvd) |=> q.st == NBP_IDLE)
		else $error("permanent lock ran while disabled");
	a_prot_status: assert property (@(posedge ref_clk) disable iff (!rstn)
		(q.st == NBP_BUSY && q.kind == NBP_K_PROT && q.tmr == '0 && !frame_end)
		|=> (stat == (q.pfail ? ST_PROT_FAIL : BYTE_ZERO)))
		else $error("status after permanent lock not 08h or 00h");
	a_pstat_cache: assert property (@(posedge ref_clk) disable iff (!rstn)
		(q.st == NBP_BUSY && q.kind == NBP_K_READ && q.tmr == '0 && mode == MODE_PSTAT && !frame_end)
		|=> q.cache == ($past(q.pbit) ? BYTE_ZERO : BYTE_ONES))
		else $error("status read cache byte wrong");
endmodule : nbp_top

/* nbp_host_model.sv */
// Purpose: Host controller model on the serial link, mode 0, 6 ns clock
// Assumes: Link clock stands still between frames
// Notes:   Released data line shows the inverse of its last bit
module nbp_host_model (
	output logic      sck,
	output logic      cs_n,
	output logic      si,
	input  wire logic so
);
	timeunit 1ns;
	timeprecision 100ps;
	import nbp_pkg::*;
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// Sends nb bytes from the top of v, then one read byte if rd
	task automatic frame(input logic [31:0] v, input int nb, input bit rd, output logic [7:0] rx);
		cs_n = 1'b0;
		#2;
		for (int i = 31; i >= 32 - 8 * nb; i--) begin
			si = v[i];
			#3 sck = 1'b1;
			#3 sck = 1'b0;
		end
		for (int i = 7; i >= 0 && rd; i--) begin
			rx[i] = so;
			#3 sck = 1'b1;
			#3 sck = 1'b0;
		end
		#2 cs_n = 1'b1;
		si = ~si;
		// Gap covers the frame spacing and the core's sync delay
		#60;
	endtask : frame
	task automatic cmd8(input logic [7:0] op);
		logic [7:0] d;
		frame({op, 24'h00_0000}, 1, 1'b0, d);
	endtask : cmd8
	task automatic setf(input logic [7:0] fa, input logic [7:0] val);
		logic [7:0] d;
		frame({OP_SETF, fa, val, 8'h00}, 3, 1'b0, d);
	endtask : setf
	task automatic cmd32(input logic [7:0] op, input logic [23:0] ad);
		logic [7:0] d;
		frame({op, ad}, 4, 1'b0, d);
	endtask : cmd32
	task automatic getf(input logic [7:0] fa, output logic [7:0] rx);
		frame({OP_GETF, fa, 16'h0000}, 2, 1'b1, rx);
	endtask : getf
	task automatic rcache(output logic [7:0] rx);
		frame({OP_RCACHE, 24'h00_0000}, 4, 1'b1, rx);
	endtask : rcache
endmodule : nbp_host_model

/* nbp_top_tb.sv */
// Purpose: Self-checking bench of the block protection core
// Assumes: Shortened program and erase times
// Notes:   Nonvolatile store is looped back only at the power cycle
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
	$display("Error at %0t: got %h expected %h", $time, a, e); end end
module nbp_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import nbp_pkg::*;
	localparam int PROG_N  = 20;
	localparam int ERASE_N = 40;
	logic                  ref_clk, rstn, wp_n, nv_disable_in;
	logic [NUM_GROUPS-1:0] nv_groups_in, grp_exp;
	wire                   sck, cs_n, si, so, so_oe, nv_disable, busy;
	wire [NUM_GROUPS-1:0]  nv_groups;
	int                    miscompares, samples_checked;
	logic [7:0]            rd;
	nbp_host_model u_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
	nbp_top #(.PROG_CYCLES(PROG_N), .ERASE_CYCLES(ERASE_N)) u_dut (
		.ref_clk(ref_clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
		.wp_n(wp_n), .nv_groups_in(nv_groups_in), .nv_disable_in(nv_disable_in),
		.nv_groups(nv_groups), .nv_disable(nv_disable), .busy(busy));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic close_out;
		$display("Checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	task automatic wait_idle;
		int n;
		n = 0;
		@(negedge ref_clk);
		while (busy !== 1'b0 && n < 5000) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 5000) begin
			miscompares++;
			close_out();
		end
	endtask : wait_idle
	function automatic logic [23:0] row_of(input int blk);
		return {7'h00, 1'b0, blk[9:0], 6'h00};
	endfunction : row_of
	function automatic logic exp_lock(input logic t, input logic [3:0] bp, input int blk);
		int n;
		n = 1 << (bp - 1);
		if (blk < 48 && grp_exp[blk / 4]) return 1'b1;
		if (bp == 4'h0) return 1'b0;
		if (bp > 4'ha) return 1'b1;
		return t ? (blk < n) : (blk >= 1024 - n);
	endfunction : exp_lock
	task automatic run_op(input logic [7:0] op, input logic [23:0] ad, input logic [7:0] exp_st);
		u_host.cmd8(OP_WREN);
		u_host.cmd32(op, ad);
		wait_idle();
		u_host.getf(FA_STAT, rd);
		`CHK(rd, exp_st)
	endtask : run_op
	task automatic pread(input int blk, input logic [7:0] exp_d);
		u_host.cmd32(OP_PREAD, row_of(blk));
		wait_idle();
		u_host.rcache(rd);
		`CHK(rd, exp_d)
	endtask : pread
	task automatic lock_rw(input logic [7:0] wv, input logic [7:0] ev);
		u_host.setf(FA_LOCK, wv);
		u_host.getf(FA_LOCK, rd);
		`CHK(rd, ev)
	endtask : lock_rw
	initial begin
		logic       t;
		logic [3:0] bp;
		logic [7:0] op;
		int         blk, span;
		rstn = 1'b0;
		wp_n = 1'b1;
		nv_disable_in = 1'b0;
		nv_groups_in = '0;
		miscompares = 0;
		samples_checked = 0;
		void'($urandom(32'h2d39905f));
		grp_exp = NUM_GROUPS'($urandom()) & 12'h3ff;
		@(posedge ref_clk) nv_groups_in <= grp_exp;
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		`CHK(nv_groups, grp_exp)
		u_host.getf(FA_LOCK, rd);
		`CHK(rd, LOCK_RESET)
		`CHK(so_oe, 1'b0)
		// Range corners first, one block just inside and one just outside the locked range for each bp from 1 to 10, then random blocks
		for (int i = 0; i < 40; i++) begin
			// Fail flags are sticky, so each pass starts clean
			u_host.cmd8(OP_RESET);
			t = 1'($urandom());
			bp = (i < 32) ? i[4:1] : 4'($urandom());
			span = (bp == 4'h0 || bp > 4'ha) ? 0 : (1 << (bp - 1));
			blk = (i >= 32) ? $urandom_range(1023) : ((t ? span - 1 + i % 2 : 1024 - span - i % 2) & 1023);
			lock_rw({1'b0, bp, t, 2'b00}, {1'b0, bp, t, 2'b00});
			op = $urandom_range(1) ? OP_PEXEC : OP_ERASE;
			run_op(op, row_of(blk), exp_lock(t, bp, blk) ? (op == OP_PEXEC ? 8'h08 : 8'h04) : 8'h00);
		end
		u_host.cmd8(OP_RESET);
		lock_rw(8'h00, 8'h00);
		u_host.cmd32(OP_PROT, {12'h000, 4'hb, 8'h00});
		`CHK(busy, 1'b0)
		wait_idle();
		`CHK(nv_groups, grp_exp)
		run_op(OP_PROT, {12'h000, 4'hb, 8'h00}, 8'h00);
		grp_exp[11] = 1'b1;
		`CHK(nv_groups, grp_exp)
		run_op(OP_PEXEC, row_of(46), 8'h08);
		// Program fail from block 46 would otherwise still show
		u_host.cmd8(OP_RESET);
		run_op(OP_ERASE, row_of(48), 8'h00);
		run_op(OP_PROT, {12'h000, 4'hc, 8'h00}, 8'h08);
		`CHK(nv_groups, grp_exp)
		u_host.setf(FA_CFG, 8'h02);
		pread(44, 8'h00);
		pread(48, 8'hff);
		u_host.setf(FA_CFG, 8'h00);
		pread(44, 8'hff);
		u_host.setf(FA_CFG, 8'h02);
		u_host.cmd8(OP_RESET);
		pread(44, 8'hff);
		// Write-disable armed while the pin is high, then frozen by the pin
		lock_rw(8'h80, 8'h80);
		@(posedge ref_clk) wp_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		lock_rw(8'h7c, 8'h80);
		u_host.getf(FA_STAT, rd);
		`CHK(rd, 8'h00)
		lock_rw(8'h02, 8'h82);
		lock_rw(8'h3e, 8'h3e);
		@(posedge ref_clk) wp_n <= 1'b1;
		u_host.cmd8(OP_RESET);
		u_host.getf(FA_LOCK, rd);
		`CHK(rd, 8'h3e)
		u_host.setf(FA_CFG, 8'hc2);
		run_op(OP_PEXEC, 24'h00_0000, 8'h00);
		`CHK(nv_disable, 1'b1)
		u_host.setf(FA_CFG, 8'h00);
		run_op(OP_PROT, {12'h000, 4'h3, 8'h00}, 8'h02);
		`CHK(nv_groups, grp_exp)
		u_host.setf(FA_CFG, 8'h20);
		u_host.getf(FA_CFG, rd);
		`CHK(rd, 8'h20)
		lock_rw(8'h00, 8'h3c);
		u_host.setf(FA_CFG, 8'h00);
		u_host.getf(FA_CFG, rd);
		`CHK(rd, 8'h20)
		// Power cycle: store loops back, lock-tight ends
		@(posedge ref_clk) nv_groups_in <= nv_groups;
		nv_disable_in <= nv_disable;
		rstn <= 1'b0;
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		u_host.getf(FA_CFG, rd);
		`CHK(rd, 8'h00)
		`CHK(nv_disable, 1'b1)
		`CHK(nv_groups, grp_exp)
		close_out();
	end
endmodule : nbp_top_tb
